// ==== hw/ceq_pkg.sv ====
// Shared constants for the channel equalize and capture block.
// Summary of operation
// - After arming, the next pulse-per-second edge becomes the master reset.
// - Time value at master reset is latched for software to read.
// - Packets start with an 8 byte counter giving acquisition time.
// - Thirty-two inputs; even output lanes used, eight streams each.
// - Four cycles between samples of a stream; reorder makes streams contiguous.
// - Each transform lane carries eight streams in order 0-4-1-5-2-6-3-7.
// - Samples are 36-bit complex, 18-bit halves with 17 fraction bits.
// - Filter bank and transform use 2048 points, giving 1024 channels.
// - Amplitude and phase tables hold 1024 host-loaded per-channel entries.
// - Real and imaginary scaled by a 32.16 gain, requantized to 18.17.
// - Phase stage complex-multiplies by 16.15 factor, giving 35.32 parts.
// - Legacy narrow branch requantizes calibrated parts to 8.7.
// - Capture strobe is rising edge of tenth bit of 13-bit counter.
// - Capture counter resets on sync leaving the last equalization stage.
// - Thirty-two captures per 8192-cycle window fill four queues, drained singly.
// - Twin capture RAMs hold identical data, addressed by remapped antenna index.
// - Port A address switches between capture write and compute read.
// - Cross product is first factor times conjugate of second factor.
// - Index tables are only read by the device; host writes them.
// - Index entries are 32 bits; low five bits give antenna 0-31.
// - At most 128 auto and 128 cross correlations are processed.
// - Software counts of antennas and correlations bound valid iterations.
package ceq_pkg;
  localparam int ARM_WINDOW_MS = 100;
  localparam int HDR_BYTES     = 8;
  localparam int HDR_W         = HDR_BYTES * 8;
  localparam int NUM_INPUTS    = 32;
  localparam int NUM_LANES     = 4;
  localparam int STREAMS_LANE  = 8;
  localparam int SAMPLE_GAP    = 4;
  localparam int FFT_POINTS    = 2048;
  localparam int NUM_CHAN      = FFT_POINTS / 2;
  localparam int CHAN_W        = 10;
  localparam int SAMP_W        = 18;
  localparam int SAMP_FRAC     = 17;
  localparam int GAIN_W        = 32;
  localparam int GAIN_FRAC     = 16;
  localparam int PH_W          = 16;
  localparam int CAL_W         = 35;
  localparam int CAL_FRAC      = 32;
  localparam int NARROW_W      = 8;
  localparam int NARROW_FRAC   = 7;
  localparam int PROD_W        = 2 * CAL_W + 1;
  localparam int CAP_CNT_W     = 13;
  localparam int CAP_BIT       = 9;
  localparam logic [9:0] CAP_CHAN = 10'h200;
  localparam int ANT_W         = 5;
  localparam int IDX_W         = 32;
  localparam int MAX_CORR      = 128;
  localparam int CNT_W         = 8;
  localparam logic [23:0] STREAM_ORDER = 24'hef2a60;
  localparam logic [2:0] TBL_AMP   = 3'h0;
  localparam logic [2:0] TBL_PHASE = 3'h1;
  localparam logic [2:0] TBL_FACA  = 3'h2;
  localparam logic [2:0] TBL_FACB  = 3'h3;
  localparam logic [2:0] TBL_POL   = 3'h4;
  typedef enum logic [1:0] {CEQ_CAPT, CEQ_WAIT, CEQ_COMP} ceq_state_t;
endpackage

// ==== hw/ceq_table.sv ====
// Host-loaded table with one write port and one registered read port.
`timescale 1ns/1ps
`default_nettype none
module ceq_table #(
  parameter int DEPTH = 1024,
  parameter int W     = 32
) (
  input  wire logic                     clk_sys,
  input  wire logic                     hostWe,
  input  wire logic [$clog2(DEPTH)-1:0] hostAddr,
  input  wire logic [W-1:0]             hostData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [W-1:0]             rdData
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) $error("ceq_table depth too small");
  end

  always_ff @(posedge clk_sys) begin
    if (hostWe) begin
      mem[hostAddr] <= hostData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ==== hw/ceq_skid.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ceq_skid #(
  parameter int W = 75
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);
  logic [W-1:0] slot_r [2];
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = slot_r[0];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (pop) begin
      slot_r[0] <= (cnt_r == 2'h2) ? slot_r[1] : inData;
    end else if (push && cnt_r == 2'h0) begin
      slot_r[0] <= inData;
    end
    if (push && ((cnt_r == 2'h1 && !pop) || cnt_r == 2'h2)) begin
      slot_r[1] <= inData;
    end
  end
endmodule
`default_nettype wire

// ==== hw/ceq_top.sv ====
// Time origin, equalization, bin capture and correlation factor fetch.
`timescale 1ns/1ps
`default_nettype none
module ceq_top #(
  parameter int NLANES = ceq_pkg::NUM_LANES,
  parameter int NCHAN  = ceq_pkg::NUM_CHAN
) (
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire logic                        armPulse,
  input  wire logic                        ppsIn,
  input  wire logic [ceq_pkg::HDR_W-1:0]   timeNow,
  output logic      [ceq_pkg::HDR_W-1:0]   originTime,
  output logic      [ceq_pkg::HDR_W-1:0]   headerCount,
  output logic                             masterRst,
  input  wire logic                        inSync,
  input  wire logic [ceq_pkg::SAMP_W-1:0]  inRe [NLANES],
  input  wire logic [ceq_pkg::SAMP_W-1:0]  inIm [NLANES],
  output logic      [ceq_pkg::NARROW_W-1:0] narrowRe [NLANES],
  output logic      [ceq_pkg::NARROW_W-1:0] narrowIm [NLANES],
  input  wire logic                        hostWe,
  input  wire logic [2:0]                  hostSel,
  input  wire logic [ceq_pkg::CHAN_W-1:0]  hostAddr,
  input  wire logic [ceq_pkg::IDX_W-1:0]   hostData,
  input  wire logic [ceq_pkg::CNT_W-1:0]   numAnt,
  input  wire logic [ceq_pkg::CNT_W-1:0]   numCorr,
  output logic                             capLost,
  output logic                             computing,
  output logic                             crossValid,
  output logic      [ceq_pkg::PROD_W-1:0]  crossRe,
  output logic      [ceq_pkg::PROD_W-1:0]  crossIm,
  output logic                             autoValid,
  output logic      [ceq_pkg::PROD_W-1:0]  autoPow
);
  localparam int SW = ceq_pkg::SAMP_W;
  localparam int CW = ceq_pkg::CAL_W;
  localparam int AW = ceq_pkg::ANT_W;
  localparam int BW = AW + 2 * CW;
  localparam int PW = ceq_pkg::PROD_W;

  initial begin
    if (NLANES * ceq_pkg::STREAMS_LANE != ceq_pkg::NUM_INPUTS) $error("lane count unsupported");
    if (NCHAN != ceq_pkg::NUM_CHAN) $error("channel count unsupported");
  end

  // Arm, pulse-per-second edge and time origin.
  logic armed_r;
  logic ppsD_r;
  logic [ceq_pkg::HDR_W-1:0] origin_r;
  logic [ceq_pkg::HDR_W-1:0] hdr_r;
  wire ppsRise = ppsIn && !ppsD_r;
  wire mstRst  = armed_r && ppsRise;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      armed_r  <= 1'b0;
      ppsD_r   <= 1'b0;
      origin_r <= '0;
      hdr_r    <= '0;
    end else begin
      ppsD_r  <= ppsIn;
      armed_r <= armPulse || (armed_r && !ppsRise);
      if (mstRst) begin
        origin_r <= timeNow;
      end
      hdr_r <= mstRst ? '0 : hdr_r + 1'b1;
    end
  end

  assign originTime  = origin_r;
  assign headerCount = hdr_r;
  assign masterRst   = mstRst;

  // Channel index and coefficient tables shared by all lanes.
  logic [ceq_pkg::CHAN_W-1:0] chan_r;
  logic [2:0] syncD_r;
  wire  [ceq_pkg::CHAN_W-1:0] chanNow = inSync ? '0 : chan_r + 1'b1;
  logic [ceq_pkg::IDX_W-1:0] ampCoef;
  logic [ceq_pkg::IDX_W-1:0] phCoef;
  wire  eqSync = syncD_r[2];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chan_r   <= '0;
      syncD_r  <= '0;
    end else begin
      chan_r   <= chanNow;
      syncD_r  <= {syncD_r[1:0], inSync};
    end
  end

  ceq_table #(.DEPTH(NCHAN), .W(ceq_pkg::IDX_W)) uAmp (
    .clk_sys (clk_sys),
    .hostWe  (hostWe && hostSel == ceq_pkg::TBL_AMP),
    .hostAddr(hostAddr),
    .hostData(hostData),
    .rdAddr  (chanNow),
    .rdData  (ampCoef)
  );

  ceq_table #(.DEPTH(NCHAN), .W(ceq_pkg::IDX_W)) uPhase (
    .clk_sys (clk_sys),
    .hostWe  (hostWe && hostSel == ceq_pkg::TBL_PHASE),
    .hostAddr(hostAddr),
    .hostData(hostData),
    .rdAddr  (chan_r),
    .rdData  (phCoef)
  );

  // Capture counter and strobe, aligned with the last stage output.
  logic [ceq_pkg::CAP_CNT_W-1:0] capCnt_r;
  logic capBitD_r;
  // The clear is taken one stage early so that count zero stands with channel zero at the output.
  wire  capClr = syncD_r[1];
  wire  capPulse = capCnt_r[ceq_pkg::CAP_BIT] && !capBitD_r;
  wire  [2:0] slot = capCnt_r[ceq_pkg::CAP_CNT_W-1:ceq_pkg::CAP_CNT_W-3];
  wire  [2:0] stream = ceq_pkg::STREAM_ORDER[3*slot +: 3];
  wire  winEnd = (capCnt_r == {ceq_pkg::CAP_CNT_W{1'b1}});

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      capCnt_r  <= '0;
      capBitD_r <= 1'b0;
    end else begin
      capCnt_r  <= capClr ? '0 : capCnt_r + 1'b1;
      capBitD_r <= capClr ? 1'b0 : capCnt_r[ceq_pkg::CAP_BIT];
    end
  end

  // Per-lane amplitude and phase stages with capture queues.
  logic [NLANES-1:0] qValid;
  logic [NLANES-1:0] qReady;
  logic [NLANES-1:0] qInReady;
  logic [BW-1:0]     qData [NLANES];
  logic [1:0]        drain_r;
  ceq_pkg::ceq_state_t state_r;
  logic              compD_r;
  logic              portRd;

  for (genvar l = 0; l < NLANES; l++) begin : gLane
    logic signed [SW-1:0] re1_r, im1_r, ampRe_r, ampIm_r;
    logic signed [CW-1:0] calRe_r, calIm_r;
    wire  signed [ceq_pkg::GAIN_W-1:0] g = ampCoef;
    wire  signed [SW+ceq_pkg::GAIN_W-1:0] pRe = re1_r * g;
    wire  signed [SW+ceq_pkg::GAIN_W-1:0] pIm = im1_r * g;
    wire  signed [ceq_pkg::PH_W-1:0] cRe = phCoef[2*ceq_pkg::PH_W-1:ceq_pkg::PH_W];
    wire  signed [ceq_pkg::PH_W-1:0] cIm = phCoef[ceq_pkg::PH_W-1:0];
    wire  signed [CW-1:0] mRe = CW'(ampRe_r) * CW'(cRe) - CW'(ampIm_r) * CW'(cIm);
    wire  signed [CW-1:0] mIm = CW'(ampRe_r) * CW'(cIm) + CW'(ampIm_r) * CW'(cRe);
    wire  [AW-1:0] ant = AW'(l * ceq_pkg::STREAMS_LANE + stream);

    always_ff @(posedge clk_sys) begin
      re1_r   <= inRe[l];
      im1_r   <= inIm[l];
      ampRe_r <= SW'(pRe >>> ceq_pkg::GAIN_FRAC);
      ampIm_r <= SW'(pIm >>> ceq_pkg::GAIN_FRAC);
      calRe_r <= mRe;
      calIm_r <= mIm;
    end

    assign narrowRe[l] = calRe_r[ceq_pkg::CAL_FRAC -: ceq_pkg::NARROW_W];
    assign narrowIm[l] = calIm_r[ceq_pkg::CAL_FRAC -: ceq_pkg::NARROW_W];
    assign qReady[l]   = (drain_r == 2'(l)) && !portRd;

    ceq_skid #(.W(BW)) uQueue (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .inValid (capPulse),
      .inReady (qInReady[l]),
      .inData  ({ant, calRe_r, calIm_r}),
      .outValid(qValid[l]),
      .outReady(qReady[l]),
      .outData (qData[l])
    );
  end

  // Twin capture RAMs, written identically from one queue at a time.
  logic [2*CW-1:0] ram0 [32];
  logic [2*CW-1:0] ram1 [32];
  wire  [BW-1:0]   wrWord = qData[drain_r];
  wire             wrEn = qValid[drain_r] && qReady[drain_r];
  logic            lost_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drain_r <= 2'h0;
      lost_r  <= 1'b0;
    end else begin
      drain_r <= drain_r + 2'h1;
      lost_r  <= lost_r || (capPulse && !(&qInReady));
    end
  end
  assign capLost = lost_r;

  // Correlation sequencer reading the host-loaded index tables.
  logic [ceq_pkg::CNT_W-1:0] idx_r;
  logic [ceq_pkg::IDX_W-1:0] facA, facB, polA;
  logic [2:0] vX_r;
  logic [2:0] vA_r;
  wire  [ceq_pkg::CNT_W-1:0] limX = (numCorr > ceq_pkg::MAX_CORR) ? 8'h80 : numCorr;
  wire  [ceq_pkg::CNT_W-1:0] limA = (numAnt > ceq_pkg::MAX_CORR) ? 8'h80 : numAnt;
  wire  [ceq_pkg::CNT_W-1:0] iter = idx_r;
  wire  lastIt = (iter + 1'b1 >= limX) && (iter + 1'b1 >= limA);
  wire  compOn = (state_r == ceq_pkg::CEQ_COMP);
  wire  [AW-1:0] rdA = facA[AW-1:0];
  wire  [AW-1:0] rdB = facB[AW-1:0];
  wire  [AW-1:0] rdP = polA[AW-1:0];
  // Port A stays on the read source one cycle past compute, when the last index fetch lands.
  assign portRd = compOn || compD_r;
  wire  [AW-1:0] addrA0 = portRd ? rdA : wrWord[BW-1 -: AW];
  wire  [AW-1:0] addrA1 = portRd ? rdB : wrWord[BW-1 -: AW];

  for (genvar t = 0; t < 3; t++) begin : gIdx
    logic [ceq_pkg::IDX_W-1:0] rd;
    ceq_table #(.DEPTH(NCHAN), .W(ceq_pkg::IDX_W)) uIdx (
      .clk_sys (clk_sys),
      .hostWe  (hostWe && hostSel == 3'(ceq_pkg::TBL_FACA + t)),
      .hostAddr(hostAddr),
      .hostData(hostData),
      .rdAddr  (ceq_pkg::CHAN_W'(iter)),
      .rdData  (rd)
    );
  end
  assign facA = gIdx[0].rd;
  assign facB = gIdx[1].rd;
  assign polA = gIdx[2].rd;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ceq_pkg::CEQ_CAPT;
      idx_r   <= '0;
      compD_r <= 1'b0;
      vX_r    <= '0;
      vA_r    <= '0;
    end else begin
      vX_r <= {vX_r[1:0], compOn && iter < limX};
      vA_r <= {vA_r[1:0], compOn && iter < limA};
      unique case (state_r)
        ceq_pkg::CEQ_CAPT: if (winEnd) state_r <= ceq_pkg::CEQ_WAIT;
        ceq_pkg::CEQ_WAIT: begin
          idx_r <= '0;
          if (!(|qValid)) state_r <= ceq_pkg::CEQ_COMP;
        end
        ceq_pkg::CEQ_COMP: begin
          idx_r <= idx_r + 1'b1;
          if (lastIt) state_r <= ceq_pkg::CEQ_CAPT;
        end
        default: state_r <= ceq_pkg::CEQ_CAPT;
      endcase
      compD_r <= compOn;
    end
  end
  assign computing = compOn;

  logic [2*CW-1:0] a_r, b_r, p_r;
  wire  signed [CW-1:0] aRe = a_r[2*CW-1:CW];
  wire  signed [CW-1:0] aIm = a_r[CW-1:0];
  wire  signed [CW-1:0] bRe = b_r[2*CW-1:CW];
  wire  signed [CW-1:0] bIm = b_r[CW-1:0];
  wire  signed [CW-1:0] pRe = p_r[2*CW-1:CW];
  wire  signed [CW-1:0] pIm = p_r[CW-1:0];
  logic [ceq_pkg::PROD_W-1:0] xRe_r, xIm_r, aPow_r;

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      ram0[addrA0] <= wrWord[2*CW-1:0];
      ram1[addrA1] <= wrWord[2*CW-1:0];
    end
    a_r    <= ram0[addrA0];
    b_r    <= ram1[addrA1];
    p_r    <= ram0[rdP];
    xRe_r  <= PW'(aRe) * PW'(bRe) + PW'(aIm) * PW'(bIm);
    xIm_r  <= PW'(aIm) * PW'(bRe) - PW'(aRe) * PW'(bIm);
    aPow_r <= PW'(pRe) * PW'(pRe) + PW'(pIm) * PW'(pIm);
  end

  assign crossValid = vX_r[2];
  assign autoValid  = vA_r[2];
  assign crossRe    = xRe_r;
  assign crossIm    = xIm_r;
  assign autoPow    = aPow_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_ARM_ORIGIN: assert property (mstRst && !armPulse |=> !armed_r)
    else $error("arm not consumed by master reset");
  AST_ORIGIN_LATCH: assert property (mstRst |=> originTime == $past(timeNow))
    else $error("origin not latched");
  AST_HDR_COUNT: assert property (!mstRst |=> headerCount == $past(headerCount) + 1'b1)
    else $error("header counter slipped");
  AST_CAP_CHAN: assert property (capPulse |-> capCnt_r[9:0] == ceq_pkg::CAP_CHAN)
    else $error("capture not at channel 512");
  AST_CAP_SINGLE: assert property (capPulse |=> !capPulse [*8])
    else $error("capture strobe too long");
  AST_CNT_ZERO: assert property (eqSync |-> capCnt_r == '0)
    else $error("capture counter not cleared by sync");
  AST_PORTA_MUX: assert property (compOn |=> addrA0 == rdA && addrA1 == rdB)
    else $error("port A not on read source");
  AST_NO_WRITE_COMP: assert property (compOn |-> !wrEn)
    else $error("RAM written during computation");
  AST_LIMIT: assert property (crossValid |-> $past(iter, 3) < 8'h80)
    else $error("cross iteration above limit");

  COV_ARM: cover property (armPulse ##[1:300] mstRst);
  COV_CAPTURE: cover property (capPulse && wrEn);
  COV_COMPUTE: cover property (crossValid && autoValid);
endmodule
`default_nettype wire

// ==== verification/ceq_board_model.sv ====
// Sampling board stand-in that makes the second pulse and channelized test streams.
`timescale 1ns/1ps
`default_nettype none
module ceq_board_model (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       ppsReq,
  input  wire logic                       streamOn,
  output logic                            ppsIn,
  output logic                            inSync,
  output logic      [ceq_pkg::SAMP_W-1:0] inRe [ceq_pkg::NUM_LANES],
  output logic      [ceq_pkg::SAMP_W-1:0] inIm [ceq_pkg::NUM_LANES]
);
  logic [12:0] chan;
  logic [3:0]  ppsLen;
  logic        hot;
  // Only channel 512 carries a tone, so a capture of any other channel shows up as zero.
  assign hot    = streamOn && chan[9:0] == 10'h200;
  // Sync marks channel zero once per 8192-cycle window, so capture windows can close.
  assign inSync = streamOn && chan == 13'h0000;
  assign ppsIn  = ppsLen != 4'h0;
  always @(negedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chan   <= 13'h0000;
      ppsLen <= 4'h0;
    end else begin
      chan   <= chan + 13'h0001;
      ppsLen <= ppsReq ? 4'h8 : (ppsIn ? ppsLen - 4'h1 : 4'h0);
    end
  end
  always_comb begin
    for (int l = 0; l < ceq_pkg::NUM_LANES; l++) begin
      inRe[l] = hot ? 18'h08000 : 18'h00000;
      inIm[l] = hot ? 18'h38000 : 18'h00000;
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_ceq_top.sv ====
// Self-checking bench for the channel equalize and capture block.
`timescale 1ns/1ps
`default_nettype none
module test_ceq_top;
  logic        clk_sys, nrst, armPulse, ppsReq, streamOn, ppsIn, inSync, masterRst;
  logic        hostWe, capLost, computing, crossValid, autoValid;
  logic [63:0] timeNow, originTime, headerCount, h0;
  logic [17:0] inRe [4], inIm [4];
  logic [7:0]  narrowRe [4], narrowIm [4], numAnt, numCorr;
  logic [2:0]  hostSel;
  logic [9:0]  hostAddr;
  logic [31:0] hostData;
  logic [70:0] crossRe, crossIm, autoPow;
  int          n_fail, checks_done;

  ceq_board_model board_u (.clk_sys(clk_sys), .nrst(nrst), .ppsReq(ppsReq),
    .streamOn(streamOn), .ppsIn(ppsIn), .inSync(inSync), .inRe(inRe), .inIm(inIm));

  ceq_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .armPulse(armPulse), .ppsIn(ppsIn),
    .timeNow(timeNow), .originTime(originTime), .headerCount(headerCount),
    .masterRst(masterRst), .inSync(inSync), .inRe(inRe), .inIm(inIm),
    .narrowRe(narrowRe), .narrowIm(narrowIm), .hostWe(hostWe), .hostSel(hostSel),
    .hostAddr(hostAddr), .hostData(hostData), .numAnt(numAnt), .numCorr(numCorr),
    .capLost(capLost), .computing(computing), .crossValid(crossValid),
    .crossRe(crossRe), .crossIm(crossIm), .autoValid(autoValid), .autoPow(autoPow));

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [70:0] got, input logic [70:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(negedge clk_sys);
  endtask

  // Bounded wait for the compute phase to reach a level; running out ends the run.
  task automatic wait_comp(input logic lvl);
    int n;
    n = 0;
    while (computing !== lvl && n < 20000) begin
      tick();
      n++;
    end
    if (n == 20000) begin
      n_fail++;
      $display("Error at %0t: compute phase wait timed out", $time);
      give_verdict();
    end
  endtask

  // Loads all entries of one table; index tables get junk in the bits above the antenna field.
  task automatic fill(input logic [2:0] sel, input logic [31:0] base, input bit idx);
    for (int a = 0; a < 1024; a++) begin
      hostWe   <= 1'b1;
      hostSel  <= sel;
      hostAddr <= a[9:0];
      hostData <= idx ? {base[31:5], a[4:0]} : base;
      tick();
    end
    hostWe <= 1'b0;
    tick();
  endtask

  // Second pulse rises at the first falling edge after the request; the reset pulse is looked at right then.
  task automatic pulse_pps(input logic expMr);
    ppsReq <= 1'b1;
    tick();
    ppsReq <= 1'b0;
    #1;
    cmp(masterRst, expMr);
    tick();
    #1;
    cmp(masterRst, 1'b0);
    repeat (12) tick();
  endtask

  task automatic test_arm();
    timeNow <= 64'h0000_0123_4567_89ab;
    pulse_pps(1'b0);
    armPulse <= 1'b1;
    tick();
    armPulse <= 1'b0;
    pulse_pps(1'b1);
    cmp(originTime, 64'h0000_0123_4567_89ab);
    timeNow <= 64'h0000_0fed_cba9_8765;
    repeat (5) tick();
    cmp(originTime, 64'h0000_0123_4567_89ab);
    $display("test_arm done");
  endtask

  task automatic test_header();
    h0 = headerCount;
    repeat (10) tick();
    cmp(headerCount - h0, 64'h000000000000000a);
    $display("test_header done");
  endtask

  task automatic test_narrow();
    int hits;
    int bad;
    hits = 0;
    bad  = 0;
    fill(ceq_pkg::TBL_AMP, 32'h00020000, 1'b0);
    fill(ceq_pkg::TBL_PHASE, 32'h40000000, 1'b0);
    streamOn <= 1'b1;
    repeat (2048) tick();
    for (int c = 0; c < 2048; c++) begin
      tick();
      for (int l = 0; l < 4; l++) begin
        if (narrowRe[l] === 8'h20 && narrowIm[l] === 8'he0) begin
          hits++;
        end else if (!(narrowRe[l] === 8'h00 && narrowIm[l] === 8'h00)) begin
          bad++;
        end
      end
    end
    cmp(hits, 8);
    cmp(bad, 0);
    $display("test_narrow done");
  endtask

  task automatic test_corr();
    int nx;
    int na;
    nx = 0;
    na = 0;
    fill(ceq_pkg::TBL_FACA, 32'hffffffe0, 1'b1);
    fill(ceq_pkg::TBL_FACB, 32'h7fffffe0, 1'b1);
    fill(ceq_pkg::TBL_POL, 32'h12345660, 1'b1);
    numAnt  <= 8'h05;
    numCorr <= 8'hc8;
    wait_comp(1'b1);
    wait_comp(1'b0);
    wait_comp(1'b1);
    for (int c = 0; c < 20000 && (computing === 1'b1 || c < 400); c++) begin
      tick();
      if (crossValid === 1'b1) begin
        nx++;
        cmp(crossRe, 71'h2000000000000000);
        cmp(crossIm, 71'h0);
      end
      if (autoValid === 1'b1) begin
        na++;
        cmp(autoPow, 71'h2000000000000000);
      end
    end
    repeat (16) begin
      tick();
      nx += (crossValid === 1'b1);
      na += (autoValid === 1'b1);
    end
    cmp(nx, 128);
    cmp(na, 5);
    cmp(capLost, 1'b0);
    cmp(computing, 1'b0);
    $display("test_corr done");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    n_fail      = 0;
    checks_done = 0;
    nrst        = 1'b0;
    armPulse    = 1'b0;
    ppsReq      = 1'b0;
    streamOn    = 1'b0;
    timeNow     = 64'h0;
    hostWe      = 1'b0;
    hostSel     = 3'h0;
    hostAddr    = 10'h000;
    hostData    = 32'h0;
    numAnt      = 8'h00;
    numCorr     = 8'h00;
    repeat (4) tick();
    nrst <= 1'b1;
    tick();
    test_arm();
    test_header();
    test_narrow();
    test_corr();
    give_verdict();
  end
endmodule
`default_nettype wire
